// [verilog/ccia_pkg.sv]
// Shared constants and types for the counter/cell interrupt and protection-byte block
package ccia_pkg;

   localparam int          ADDR_W          = 8;
   localparam int          DATA_W          = 16;

   // Register offsets
   localparam logic [7:0]  OFS_EVENT_EN    = 8'h2E;
   localparam logic [7:0]  OFS_OVFL_EN     = 8'h2F;
   localparam logic [7:0]  OFS_CELL_EN     = 8'h30;
   localparam logic [7:0]  OFS_APS_TX      = 8'h32;
   localparam logic [7:0]  OFS_APS_RX      = 8'h33;
   localparam logic [7:0]  OFS_EVENT_ST    = 8'h39;
   localparam logic [7:0]  OFS_OVFL_ST     = 8'h3A;
   localparam logic [7:0]  OFS_CELL_ST     = 8'h3B;

   // Reset values
   localparam logic [15:0] RST_ENABLE      = 16'h0000;
   localparam logic [15:0] RST_STATUS      = 16'h0000;
   localparam logic [15:0] RST_APS_TX      = 16'h0000;
   localparam logic [15:0] RST_APS_RX      = 16'h0000;
   localparam logic [15:0] RD_UNMAPPED     = 16'h0000;

   // Field positions
   localparam int          APS_FIRST_MSB   = 15;
   localparam int          APS_FIRST_LSB   = 8;
   localparam int          APS_SECOND_MSB  = 7;
   localparam int          APS_SECOND_LSB  = 0;
   localparam int          APS_CHANGE_BIT  = 12;
   localparam int          OVFL_LINE_LSB   = 7;
   localparam int          CELL_TX_OVF_LSB = 12;
   localparam int          CELL_RX_OVF_LSB = 8;
   localparam int          CELL_MATCH_LSB  = 4;
   localparam int          CELL_SENT_LSB   = 0;

   // Only the protection-change bit lives in this block's event pair
   localparam logic [15:0] EVENT_IMPL_MASK = 16'h1000;

   typedef struct packed {
      logic [7:0] first;
      logic [7:0] second;
   } ccia_kbytes_t;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic              wr;
      logic              rd;
   } ccia_bus_req_t;

endpackage

// [verilog/ccia_sticky.sv]
// One status/enable pair: sticky write-one-to-clear status gated by its enable
`timescale 1ns/1ps
`default_nettype none
module ccia_sticky
   import ccia_pkg::*;
#(
   parameter int W = 16
) (
   input  wire logic         mclk,
   input  wire logic         resetn,
   input  wire logic [W-1:0] set_evt,
   input  wire logic         wr_status,
   input  wire logic         wr_enable,
   input  wire logic [W-1:0] wdata,
   output var  logic [W-1:0] status,
   output var  logic [W-1:0] enable,
   output var  logic         irq_any
);

   logic [W-1:0] next_status;

   // Set wins over a simultaneous clear so no event is lost
   always_comb begin
      next_status = status;
      if (wr_status) begin
         next_status = next_status & ~wdata;
      end
      next_status = next_status | set_evt;
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         status <= RST_STATUS[W-1:0];
      end else begin
         status <= next_status;
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         enable <= RST_ENABLE[W-1:0];
      end else if (wr_enable) begin
         enable <= wdata;
      end
   end

   assign irq_any = |(status & enable);

endmodule
`default_nettype wire

// [verilog/ccia_top.sv]
// Counter overflow and cell interrupt enables, protection byte registers, status interrupt
// Function
// - Overflow enable register at 0x2F gates each same-position bit of overflow status at 0x3A onto the interrupt.
// - Overflow enable bits 15..7 cover line error counters 9..1, one counter per bit.
// - Overflow enable bits 6..0 cover idle, unmatched, nonzero flow control, length, payload check, uncorrected, corrected.
// - Cell enable register at 0x30 gates each same-position bit of cell status at 0x3B onto the interrupt.
// - Cell enable bits 15..12 cover transmitted-cell tally overflow for ports 3..0.
// - Cell enable bits 11..8 cover received-cell tally overflow for ports 3..0.
// - Cell enable bits 7..4 cover the header-match event of ports 3..0.
// - Cell enable bits 3..0 cover a cell sent from ports 3..0.
// - Register 0x32 holds the first protection byte in 15..8 and the second in 7..0 for the transmitter.
// - Register 0x33 holds the last received first byte in 15..8 and second byte in 7..0.
// - A received protection byte that differs from the held value sets event status bit 12.
// - A status bit reaches the interrupt only while its enable bit is set.
// - Event enable bit 12 lets the protection-change event drive the interrupt.
`timescale 1ns/1ps
`default_nettype none
module ccia_top
   import ccia_pkg::*;
(
   input  wire logic              mclk,
   input  wire logic              resetn,
   input  wire logic [ADDR_W-1:0] reg_addr,
   input  wire logic [DATA_W-1:0] reg_wdata,
   input  wire logic              reg_wr,
   input  wire logic              reg_rd,
   output var  logic [DATA_W-1:0] reg_rdata,
   input  wire logic [15:0]       ovfl_event,
   input  wire logic [15:0]       cell_event,
   input  wire logic              rx_aps_valid,
   input  wire ccia_kbytes_t      rx_aps,
   output var  ccia_kbytes_t      tx_aps,
   output var  logic              stat_int
);

   ccia_bus_req_t req;
   logic [15:0]   ovfl_status;
   logic [15:0]   ovfl_enable;
   logic [15:0]   cell_status;
   logic [15:0]   cell_enable;
   logic [15:0]   event_status;
   logic [15:0]   event_enable;
   logic [15:0]   ovfl_pend;
   logic [15:0]   cell_pend;
   logic [15:0]   event_pend;
   logic [8:0]    pend_line;
   logic [6:0]    pend_tally;
   logic [3:0]    pend_tx_ovf;
   logic [3:0]    pend_rx_ovf;
   logic [3:0]    pend_match;
   logic [3:0]    pend_sent;
   logic          pend_aps;
   logic          any_pend;
   logic [15:0]   aps_transmit_bytes;
   logic [15:0]   aps_receive_bytes;
   logic          aps_change;
   logic [15:0]   event_set;

   function automatic logic hit(input logic [ADDR_W-1:0] ofs);
      hit = req.wr && (req.addr == ofs);
   endfunction

   // Enabled view of one status word; shared by all three pairs
   function automatic logic [15:0] gated(input logic [15:0] st, input logic [15:0] en);
      gated = st & en;
   endfunction

   assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

   // Overflow pair: bits 15..7 line counters 9..1, 6..0 cell tallies
   ccia_sticky #(.W(16)) u_ovfl (
      .mclk      (mclk),
      .resetn    (resetn),
      .set_evt   (ovfl_event),
      .wr_status (hit(OFS_OVFL_ST)),
      .wr_enable (hit(OFS_OVFL_EN)),
      .wdata     (req.wdata),
      .status    (ovfl_status),
      .enable    (ovfl_enable),
      .irq_any   ()
   );

   // Cell pair: tx overflow, rx overflow, header match, cell sent; port 3 highest
   ccia_sticky #(.W(16)) u_cell (
      .mclk      (mclk),
      .resetn    (resetn),
      .set_evt   (cell_event),
      .wr_status (hit(OFS_CELL_ST)),
      .wr_enable (hit(OFS_CELL_EN)),
      .wdata     (req.wdata),
      .status    (cell_status),
      .enable    (cell_enable),
      .irq_any   ()
   );

   // Event pair keeps only the protection-change bit
   ccia_sticky #(.W(16)) u_event (
      .mclk      (mclk),
      .resetn    (resetn),
      .set_evt   (event_set),
      .wr_status (hit(OFS_EVENT_ST)),
      .wr_enable (hit(OFS_EVENT_EN)),
      .wdata     (req.wdata & EVENT_IMPL_MASK),
      .status    (event_status),
      .enable    (event_enable),
      .irq_any   ()
   );

   // Transmit bytes
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         aps_transmit_bytes <= RST_APS_TX;
      end else if (hit(OFS_APS_TX)) begin
         aps_transmit_bytes <= req.wdata;
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         tx_aps <= '0;
      end else begin
         tx_aps.first  <= aps_transmit_bytes[APS_FIRST_MSB:APS_FIRST_LSB];
         tx_aps.second <= aps_transmit_bytes[APS_SECOND_MSB:APS_SECOND_LSB];
      end
   end

   // Receive bytes; compare against the held copy before it is replaced
   assign aps_change = rx_aps_valid && (rx_aps != aps_receive_bytes);

   always_comb begin
      event_set = '0;
      event_set[APS_CHANGE_BIT] = aps_change;
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         aps_receive_bytes <= RST_APS_RX;
      end else if (rx_aps_valid) begin
         aps_receive_bytes <= rx_aps;
      end
   end

   assign ovfl_pend  = gated(ovfl_status, ovfl_enable);
   assign cell_pend  = gated(cell_status, cell_enable);
   assign event_pend = gated(event_status, event_enable);

   // Line/PHY error counters 9..1 on overflow bits 15..7
   always_comb begin
      pend_line = '0;
      for (int i = 0; i < $bits(pend_line); i++) begin
         pend_line[i] = ovfl_pend[OVFL_LINE_LSB + i];
      end
   end

   // Cell tallies on overflow bits 6..0, idle cell highest
   always_comb begin
      pend_tally = '0;
      for (int i = 0; i < $bits(pend_tally); i++) begin
         pend_tally[i] = ovfl_pend[i];
      end
   end

   // Transmitted-cell tally overflow, port 3 on the highest bit
   always_comb begin
      pend_tx_ovf[3] = cell_pend[CELL_TX_OVF_LSB + 3];
      pend_tx_ovf[2] = cell_pend[CELL_TX_OVF_LSB + 2];
      pend_tx_ovf[1] = cell_pend[CELL_TX_OVF_LSB + 1];
      pend_tx_ovf[0] = cell_pend[CELL_TX_OVF_LSB];
   end

   // Received-cell tally overflow, port 3 on the highest bit
   always_comb begin
      pend_rx_ovf[3] = cell_pend[CELL_RX_OVF_LSB + 3];
      pend_rx_ovf[2] = cell_pend[CELL_RX_OVF_LSB + 2];
      pend_rx_ovf[1] = cell_pend[CELL_RX_OVF_LSB + 1];
      pend_rx_ovf[0] = cell_pend[CELL_RX_OVF_LSB];
   end

   // Header-match events per port
   always_comb begin
      pend_match[3] = cell_pend[CELL_MATCH_LSB + 3];
      pend_match[2] = cell_pend[CELL_MATCH_LSB + 2];
      pend_match[1] = cell_pend[CELL_MATCH_LSB + 1];
      pend_match[0] = cell_pend[CELL_MATCH_LSB];
   end

   // Cell-sent events per port
   always_comb begin
      pend_sent[3] = cell_pend[CELL_SENT_LSB + 3];
      pend_sent[2] = cell_pend[CELL_SENT_LSB + 2];
      pend_sent[1] = cell_pend[CELL_SENT_LSB + 1];
      pend_sent[0] = cell_pend[CELL_SENT_LSB];
   end

   assign pend_aps = event_pend[APS_CHANGE_BIT];

   // One OR tree over every enabled group feeds the pin
   always_comb begin
      any_pend = 1'b0;
      any_pend = any_pend | (|pend_line);
      any_pend = any_pend | (|pend_tally);
      any_pend = any_pend | (|pend_tx_ovf);
      any_pend = any_pend | (|pend_rx_ovf);
      any_pend = any_pend | (|pend_match);
      any_pend = any_pend | (|pend_sent);
      any_pend = any_pend | pend_aps;
   end

   // Registered so the pin is glitch-free; costs one cycle of latency
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         stat_int <= 1'b0;
      end else begin
         stat_int <= any_pend;
      end
   end

   // Read data valid the cycle after the strobe only
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         reg_rdata <= RD_UNMAPPED;
      end else if (!req.rd) begin
         reg_rdata <= RD_UNMAPPED;
      end else begin
         case (req.addr)
            OFS_EVENT_EN: begin
               reg_rdata <= event_enable;
            end
            OFS_OVFL_EN: begin
               reg_rdata <= ovfl_enable;
            end
            OFS_CELL_EN: begin
               reg_rdata <= cell_enable;
            end
            OFS_APS_TX: begin
               reg_rdata <= aps_transmit_bytes;
            end
            OFS_APS_RX: begin
               reg_rdata <= aps_receive_bytes;
            end
            OFS_EVENT_ST: begin
               reg_rdata <= event_status;
            end
            OFS_OVFL_ST: begin
               reg_rdata <= ovfl_status;
            end
            OFS_CELL_ST: begin
               reg_rdata <= cell_status;
            end
            default: begin
               reg_rdata <= RD_UNMAPPED;
            end
         endcase
      end
   end

endmodule
`default_nettype wire

// [sim/ccia_top_assertions.sv]
// Port-level checks for the interrupt enable and protection byte block
`timescale 1ns/1ps
`default_nettype none
module ccia_top_assertions
   import ccia_pkg::*;
(
   input wire logic              mclk,
   input wire logic              resetn,
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [DATA_W-1:0] reg_wdata,
   input wire logic              reg_wr,
   input wire logic              reg_rd,
   input wire logic [DATA_W-1:0] reg_rdata,
   input wire logic [15:0]       ovfl_event,
   input wire logic [15:0]       cell_event,
   input wire logic              rx_aps_valid,
   input wire ccia_kbytes_t      rx_aps,
   input wire ccia_kbytes_t      tx_aps,
   input wire logic              stat_int
);
   logic [15:0] ov_en;
   logic [15:0] ce_en;
   default clocking @(posedge mclk); endclocking
   default disable iff (!resetn);
   // Enable shadows rebuilt from bus writes
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         ov_en <= 16'h0000;
         ce_en <= 16'h0000;
      end else if (reg_wr && reg_addr == OFS_OVFL_EN) begin
         ov_en <= reg_wdata;
      end else if (reg_wr && reg_addr == OFS_CELL_EN) begin
         ce_en <= reg_wdata;
      end
   end
   sequence quiet2;
      !reg_wr ##1 !reg_wr;
   endsequence
   sequence tx_wr;
      reg_wr && reg_addr == OFS_APS_TX;
   endsequence
   rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 16'h0000) else $error("stray read data");
   tx_follow_a: assert property (tx_wr |-> ##2 tx_aps == $past(reg_wdata, 2)) else $error("tx bytes");
   ovfl_int_a: assert property ((ovfl_event & ov_en) != 16'h0000 ##0 quiet2 |-> ##1 stat_int)
      else $error("overflow irq missing");
   cell_int_a: assert property ((cell_event & ce_en) != 16'h0000 ##0 quiet2 |-> ##1 stat_int)
      else $error("cell irq missing");
   int_rise_a: assert property ($rose(stat_int) |-> $past(reg_wr, 2) || $past(rx_aps_valid, 2)
      || $past(ovfl_event, 2) != 16'h0000 || $past(cell_event, 2) != 16'h0000) else $error("irq no cause");
   int_fall_a: assert property ($fell(stat_int) |-> $past(reg_wr, 2)) else $error("irq dropped");
   ovfl_rd_a: assert property (reg_rd && reg_addr == OFS_OVFL_EN |=> reg_rdata == ov_en) else $error("ovfl en");
   tx_rd_a: assert property (reg_rd && reg_addr == OFS_APS_TX |=> reg_rdata == tx_aps) else $error("tx read");
endmodule
bind ccia_top ccia_top_assertions u_chk (.*);
`default_nettype wire

// [sim/test_ccia_top.sv]
// Self-checking bench for the interrupt enable and protection byte block
`timescale 1ns/1ps
`default_nettype none
module test_ccia_top
   import ccia_pkg::*;
;
   logic         mclk, resetn, reg_wr, reg_rd, rx_aps_valid, stat_int;
   logic [7:0]   reg_addr, en_a, st_a;
   logic [15:0]  reg_wdata, reg_rdata, ovfl_event, cell_event, b;
   ccia_kbytes_t rx_aps, tx_aps;
   int           bad_count = 0;
   int           total_checks = 0;
   int           cycles = 0;
   logic [39:0]  rows [6] = '{{OFS_EVENT_EN, 16'hFFFF, 16'h1000}, {OFS_OVFL_EN, 16'hFFFF, 16'hFFFF},
      {OFS_CELL_EN, 16'hA5C3, 16'hA5C3}, {OFS_APS_TX, 16'h1234, 16'h1234},
      {OFS_APS_RX, 16'hBEEF, RST_APS_RX}, {8'h31, 16'hFFFF, RD_UNMAPPED}};
   ccia_top dut (.*);
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge mclk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge mclk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [15:0] exp);
      @(posedge mclk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1;
      chk(reg_rdata, exp);
   endtask
   task automatic ev(input logic [15:0] o, input logic [15:0] c, input logic v, input logic [15:0] k);
      @(posedge mclk);
      ovfl_event <= o;
      cell_event <= c;
      rx_aps_valid <= v;
      rx_aps <= k;
      @(posedge mclk);
      ovfl_event <= 16'h0000;
      cell_event <= 16'h0000;
      rx_aps_valid <= 1'b0;
      rx_aps <= ~k;
   endtask
   // Status then registered irq: two edges of lag
   task automatic settle(input logic e);
      repeat (2) @(posedge mclk);
      #1;
      chk({15'h0000, stat_int}, {15'h0000, e});
   endtask
   task automatic give_verdict;
      if (bad_count == 0 && total_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 20000) begin
         bad_count++;
         give_verdict();
      end
   end
   initial begin
      {resetn, reg_wr, reg_rd, rx_aps_valid, reg_addr, reg_wdata} = '0;
      {ovfl_event, cell_event, rx_aps} = '0;
      repeat (8) @(posedge mclk);
      resetn <= 1'b1;
      foreach (rows[r]) begin
         rd(rows[r][39:32], RST_ENABLE);
         wr(rows[r][39:32], rows[r][31:16]);
         rd(rows[r][39:32], rows[r][15:0]);
      end
      chk(tx_aps, 16'h1234);
      wr(OFS_OVFL_EN, 16'h0000);
      wr(OFS_CELL_EN, 16'h0000);
      for (int p = 0; p < 2; p++) begin
         en_a = p ? OFS_CELL_EN : OFS_OVFL_EN;
         st_a = p ? OFS_CELL_ST : OFS_OVFL_ST;
         for (int i = 0; i < 16; i++) begin
            b = 16'h0001 << i;
            wr(en_a, ~b);
            ev(p ? 16'h0000 : b, p ? b : 16'h0000, 1'b0, 16'h0000);
            settle(1'b0);
            rd(st_a, b);
            wr(en_a, b);
            ev(p ? 16'h0000 : b, p ? b : 16'h0000, 1'b0, 16'h0000);
            settle(1'b1);
            wr(st_a, b);
            settle(1'b0);
         end
      end
      // Event and clear in one cycle: the event must survive
      @(posedge mclk);
      reg_addr <= OFS_CELL_ST;
      reg_wdata <= 16'h0001;
      reg_wr <= 1'b1;
      cell_event <= 16'h0001;
      @(posedge mclk);
      reg_wr <= 1'b0;
      cell_event <= 16'h0000;
      rd(OFS_CELL_ST, 16'h0001);
      wr(OFS_CELL_ST, 16'h0001);
      ev(16'h0000, 16'h0000, 1'b1, 16'hABCD);
      settle(1'b1);
      rd(OFS_APS_RX, 16'hABCD);
      rd(OFS_EVENT_ST, 16'h1000);
      wr(OFS_EVENT_ST, 16'h1000);
      settle(1'b0);
      ev(16'h0000, 16'h0000, 1'b1, 16'hABCD);
      settle(1'b0);
      wr(OFS_EVENT_EN, 16'h0000);
      ev(16'h0000, 16'h0000, 1'b1, 16'hAB00);
      settle(1'b0);
      wr(OFS_EVENT_EN, 16'h1000);
      settle(1'b1);
      // Mid-run reset must clear the event enable and the level, checked after a read
      @(posedge mclk);
      resetn <= 1'b0;
      @(posedge mclk);
      resetn <= 1'b1;
      rd(OFS_EVENT_EN, RST_ENABLE);
      chk({15'h0000, stat_int}, 16'h0000);
      give_verdict();
   end
endmodule
`default_nettype wire
